/* File: logic/balance_gate_cfg.svh */
`ifndef BALANCE_GATE_CFG_SVH
`define BALANCE_GATE_CFG_SVH

`define CELL_COUNT      6
`define ADDR_WIDTH      5
`define CMD_WIDTH       16
`define CRC_WIDTH       4
`define MSG_WIDTH       12
`define CRC_POLY        4'h3
`define CRC_INVERT      4'hF
`define MSG_MSB         15
`define CRC_MSB         3
`define CELL_FIELD_W    2
`define CELL_DISCHARGE  2'h1
`define PRI_TIMER_W     16
`define SEC_TIMER_W     16
`define TIMER_ZERO      16'h0000
`define TIMER_ONE       16'h0001

`endif

/* File: logic/balance_gate_pkg.sv */
package balance_gate_pkg;
  `include "balance_gate_cfg.svh"

  // Per-cell command field: two bits per cell, cell 0 in the most significant bits
  typedef logic [`CELL_FIELD_W-1:0] cell_cmd_t;

  typedef struct packed {
    logic [`MSG_WIDTH-1:0] message;
    logic [`CRC_WIDTH-1:0] crc_inv;
  } balance_word_t;

  typedef struct packed {
    logic [`CELL_COUNT-1:0] primary_on;
    logic [`CELL_COUNT-1:0] secondary_on;
  } switch_drive_t;

  typedef enum logic [1:0] {
    IDLE,
    PRIMARY_ON,
    SECONDARY_ON
  } switch_state_t;
endpackage

/* File: logic/balance_command_fault_gate.sv */
`timescale 1ns/1ps
`include "balance_gate_cfg.svh"

// Notes on behaviour
// (RL1) Device answers only writes whose 5-bit address matches its strapped address.
// (RL2) Every balance write is a full 16-bit word regardless of cells used.
// (RL3) Unused cell positions never balance, yet their bits enter the CRC.
// (RL4) A write with nonzero CRC remainder is dropped; execute cannot apply it.
// (RL5) A nonzero CRC remainder on a write turns all balancers off.
// (RL6) Corrupted reads leave balancing per the last write that passed CRC.
// (RL7) Host checks readback CRC and distrusts data with nonzero remainder.
// (RL8) Secondary-winding overvoltage stops all balancing.
// (RL9) Primary on-period ends at maximum on-time unless peak current ended it.
// (RL10) Secondary on-period ends at maximum on-time unless peak current ended it.
// (RL11) CRC x^4+x+1 over first 12 bits MSB first; CRC bits sent inverted.
// (RL12) From reset until first good write, every balancer stays off.
module balance_command_fault_gate
  import balance_gate_pkg::*;
(
  input  wire logic                    core_clk_i,
  input  wire logic                    reset_n_i,
  input  wire logic [`ADDR_WIDTH-1:0]  device_addr_i,
  input  wire logic                    write_valid_i,
  input  wire logic [`ADDR_WIDTH-1:0]  write_addr_i,
  input  wire balance_word_t           write_word_i,
  input  wire logic                    execute_i,
  input  wire logic                    suspend_i,
  input  wire logic [`CELL_COUNT-1:0]  cell_used_i,
  input  wire logic                    secondary_overvoltage_sense_pin_i,
  input  wire logic                    primary_peak_i,
  input  wire logic                    secondary_peak_i,
  input  wire logic [`PRI_TIMER_W-1:0] primary_max_on_time_set_i,
  input  wire logic [`SEC_TIMER_W-1:0] secondary_max_on_time_set_i,
  output logic                         crc_error_o,
  output balance_word_t                readback_word_o,
  output switch_drive_t                drive_o
);

  // CRC remainder of a 12-bit message, MSB first
  // Bit-serial form keeps each step to a few gates
  function automatic logic [`CRC_WIDTH-1:0] crc4(input logic [`MSG_WIDTH-1:0] msg);
    logic [`CRC_WIDTH-1:0] r;
    logic                  fb;
    r = '0;
    for (int i = `MSG_WIDTH - 1; i >= 0; i--) begin
      fb = r[`CRC_MSB] ^ msg[i];
      r  = {r[`CRC_MSB-1:0], 1'h0} ^ (fb ? `CRC_POLY : 4'h0); // [RL11]
    end
    return r;
  endfunction

  // Pin input synchroniser: three stages, change taken when last two agree
  // One stage could pass a metastable level; two agreeing stages filter it
  logic [2:0] ov_sync_reg;
  logic [2:0] ov_sync_next;
  logic       ov_reg;
  logic       ov_next;

  always_comb begin
    ov_sync_next = {ov_sync_reg[1:0], secondary_overvoltage_sense_pin_i};
    ov_next      = (ov_sync_reg[2] == ov_sync_reg[1]) ? ov_sync_reg[2] : ov_reg;
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      ov_sync_reg <= 3'h0;
      ov_reg      <= 1'h0;
    end else begin
      ov_sync_reg <= ov_sync_next;
      ov_reg      <= ov_next;
    end
  end

  // Command acceptance
  // Active word survives faults; enable alone gates switching
  logic                  addr_hit;
  logic                  crc_ok;
  logic [`MSG_WIDTH-1:0] staged_reg;
  logic [`MSG_WIDTH-1:0] staged_next;
  logic                  staged_ok_reg;
  logic                  staged_ok_next;
  logic [`MSG_WIDTH-1:0] active_reg;
  logic [`MSG_WIDTH-1:0] active_next;
  logic                  enabled_reg;
  logic                  enabled_next;
  logic                  crc_err_reg;
  logic                  crc_err_next;
  balance_word_t         readback_reg;
  balance_word_t         readback_next;

  assign addr_hit = write_valid_i && (write_addr_i == device_addr_i);  // [RL1]
  // Full word including unused-cell bits feeds the check
  assign crc_ok   = ((crc4(write_word_i.message) ^ `CRC_INVERT)
                     == write_word_i.crc_inv);  // [RL2] [RL3] [RL11]

  always_comb begin
    staged_next    = staged_reg;
    staged_ok_next = staged_ok_reg;
    active_next    = active_reg;
    enabled_next   = enabled_reg;
    crc_err_next   = crc_err_reg;
    readback_next  = readback_reg;
    // Write beats a same-cycle execute; the execute is simply lost
    if (addr_hit) begin
      if (crc_ok) begin
        staged_next    = write_word_i.message;
        staged_ok_next = 1'h1;
        crc_err_next   = 1'h0;
        // Readback mirrors only words that passed the check
        readback_next  = write_word_i;
      end else begin
        // Staged word is dropped so no later execute can apply it
        staged_ok_next = 1'h0;                // [RL4]
        enabled_next   = 1'h0;                // [RL5]
        crc_err_next   = 1'h1;
      end
    end else if (execute_i && staged_ok_reg) begin
      // Reads never reach here, so balancing keeps the last good command
      active_next  = staged_reg;              // [RL6]
      enabled_next = 1'h1;                    // [RL12]
    end
    // Shutdown wins over a same-cycle execute; a fresh execute restarts
    if (suspend_i || ov_reg) begin
      enabled_next = 1'h0;                    // [RL8]
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      staged_reg    <= '0;
      staged_ok_reg <= 1'h0;
      active_reg    <= '0;
      enabled_reg   <= 1'h0;                  // [RL12]
      crc_err_reg   <= 1'h0;
      readback_reg  <= '0;
    end else begin
      staged_reg    <= staged_next;
      staged_ok_reg <= staged_ok_next;
      active_reg    <= active_next;
      enabled_reg   <= enabled_next;
      crc_err_reg   <= crc_err_next;
      readback_reg  <= readback_next;
    end
  end

  assign crc_error_o     = crc_err_reg;
  assign readback_word_o = readback_reg;

  // Per-cell switching: field 00 idle, 01 discharge (primary), 1x charge (secondary)
  logic          [`CELL_COUNT-1:0] pri_req;
  logic          [`CELL_COUNT-1:0] sec_req;
  switch_state_t                   st_reg   [`CELL_COUNT];
  switch_state_t                   st_next  [`CELL_COUNT];
  logic          [`PRI_TIMER_W-1:0] tmr_reg [`CELL_COUNT];
  logic          [`PRI_TIMER_W-1:0] tmr_next[`CELL_COUNT];
  switch_drive_t                   drive_reg;
  switch_drive_t                   drive_next;

  always_comb begin
    cell_cmd_t f;
    f = '0;
    for (int c = 0; c < `CELL_COUNT; c++) begin
      f = active_reg[`MSG_WIDTH-1-`CELL_FIELD_W*c -: `CELL_FIELD_W];
      // Unused cells never switch, whatever their field holds
      pri_req[c] = enabled_reg && cell_used_i[c] && (f == `CELL_DISCHARGE); // [RL3]
      sec_req[c] = enabled_reg && cell_used_i[c] && f[1];        // [RL3]
    end
  end

  always_comb begin
    for (int c = 0; c < `CELL_COUNT; c++) begin
      st_next[c]  = st_reg[c];
      // Timer restarts on each entry, so every on-period gets the full limit
      tmr_next[c] = tmr_reg[c] + `TIMER_ONE;
      unique case (st_reg[c])
        IDLE: begin
          tmr_next[c] = `TIMER_ZERO;
          if (pri_req[c]) begin
            st_next[c] = PRIMARY_ON;
          end else if (sec_req[c]) begin
            st_next[c] = SECONDARY_ON;
          end
        end
        // Limitation: peak inputs are shared, so one peak ends every cell on its winding
        PRIMARY_ON: begin
          if (!pri_req[c] || primary_peak_i ||
              tmr_reg[c] >= primary_max_on_time_set_i) begin           // [RL9]
            st_next[c] = IDLE;
          end
        end
        SECONDARY_ON: begin
          if (!sec_req[c] || secondary_peak_i ||
              tmr_reg[c] >= secondary_max_on_time_set_i) begin         // [RL10]
            st_next[c] = IDLE;
          end
        end
      endcase
      drive_next.primary_on[c]   = (st_next[c] == PRIMARY_ON);
      drive_next.secondary_on[c] = (st_next[c] == SECONDARY_ON);
    end
  end

  // Drive comes from flops fed by the next state, so it never glitches
  always_ff @(posedge core_clk_i) begin
    for (int c = 0; c < `CELL_COUNT; c++) begin
      if (!reset_n_i) begin
        st_reg[c]  <= IDLE;
        tmr_reg[c] <= `TIMER_ZERO;
      end else begin
        st_reg[c]  <= st_next[c];
        tmr_reg[c] <= tmr_next[c];
      end
    end
    if (!reset_n_i) begin
      drive_reg <= '0;
    end else begin
      drive_reg <= drive_next;
    end
  end

  assign drive_o = drive_reg;

endmodule

/* File: dv/host_model.sv */
`timescale 1ns/1ps
module host_model
  import balance_gate_pkg::*;
(
  input  wire logic    clk_i,
  input  balance_word_t rb_i,
  output logic          valid_o,
  output logic [4:0]    addr_o,
  output balance_word_t word_o,
  output logic          rb_ok_o
);
  function automatic logic [3:0] crc4(input logic [11:0] m);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 11; i >= 0; i--) begin
      r = {r[2:0], 1'h0} ^ ((r[3] ^ m[i]) ? 4'h3 : 4'h0);
    end
    return r;
  endfunction
  // Readback trusted only with zero remainder
  assign rb_ok_o = crc4(rb_i.message) == ~rb_i.crc_inv;
  initial begin
    valid_o = 1'h0;
    addr_o = 5'h00;
    word_o = 16'h0000;
  end
  // Bad flips one check bit; word is always sent whole
  task automatic send(input logic [4:0] a, input logic [11:0] m, input logic bad);
    @(posedge clk_i);
    valid_o <= 1'h1;
    addr_o <= a;
    word_o <= {m, ~crc4(m) ^ {3'h0, bad}};
    @(posedge clk_i);
    valid_o <= 1'h0;
    word_o <= ~word_o;
  endtask
endmodule

/* File: dv/balance_command_fault_gate_properties.sv */
`timescale 1ns/1ps
`include "balance_gate_cfg.svh"
module balance_command_fault_gate_properties
  import balance_gate_pkg::*;
(
  input wire logic                    core_clk_i,
  input wire logic                    reset_n_i,
  input wire logic [`ADDR_WIDTH-1:0]  device_addr_i,
  input wire logic                    write_valid_i,
  input wire logic [`ADDR_WIDTH-1:0]  write_addr_i,
  input wire balance_word_t           write_word_i,
  input wire logic                    execute_i,
  input wire logic                    suspend_i,
  input wire logic [`CELL_COUNT-1:0]  cell_used_i,
  input wire logic                    secondary_overvoltage_sense_pin_i,
  input wire logic                    primary_peak_i,
  input wire logic                    secondary_peak_i,
  input wire logic [`PRI_TIMER_W-1:0] primary_max_on_time_set_i,
  input wire logic [`SEC_TIMER_W-1:0] secondary_max_on_time_set_i,
  input wire logic                    crc_error_o,
  input wire balance_word_t           readback_word_o,
  input wire switch_drive_t           drive_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [15:0] pri_reg, pri_next, sec_reg, sec_next;
  wire hit = write_valid_i && write_addr_i == device_addr_i;
  // Lengths of unbroken on-runs
  always_comb begin
    pri_next = (|drive_o.primary_on) ? pri_reg + 16'h0001 : 16'h0000;
    sec_next = (|drive_o.secondary_on) ? sec_reg + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge core_clk_i) begin
    pri_reg <= reset_n_i ? pri_next : 16'h0000;
    sec_reg <= reset_n_i ? sec_next : 16'h0000;
  end
  chk_bad_write_off: assert property (hit |=> crc_error_o |-> ##2 drive_o == '0)
    else $error("drive left on after bad write");
  chk_good_readback: assert property (
    hit |=> crc_error_o || readback_word_o == $past(write_word_i)) else $error("readback lost");
  chk_bad_held: assert property (hit |=> !crc_error_o || $stable(readback_word_o))
    else $error("bad write applied");
  chk_foreign_addr: assert property (
    write_valid_i && !hit |=> $stable(readback_word_o) && $stable(crc_error_o))
    else $error("foreign write taken");
  chk_unused_idle: assert property (
    ((drive_o.primary_on | drive_o.secondary_on) & ~cell_used_i) == '0) else $error("unused on");
  chk_ovp_stop: assert property (secondary_overvoltage_sense_pin_i [*7] |-> drive_o == '0)
    else $error("overvoltage ignored");
  chk_pri_max_on: assert property (pri_reg <= primary_max_on_time_set_i + 16'h0002)
    else $error("primary on too long");
  chk_sec_max_on: assert property (sec_reg <= secondary_max_on_time_set_i + 16'h0002)
    else $error("secondary on too long");
  chk_pri_peak_end: assert property (
    primary_peak_i |=> (drive_o.primary_on & $past(drive_o.primary_on)) == '0)
    else $error("primary peak ignored");
  chk_sec_peak_end: assert property (
    secondary_peak_i |=> (drive_o.secondary_on & $past(drive_o.secondary_on)) == '0)
    else $error("secondary peak ignored");
  chk_reset_quiet: assert property (disable iff (1'h0)
    !reset_n_i |=> drive_o == '0 && !crc_error_o) else $error("active out of reset");
  cover property (hit ##1 crc_error_o);
  cover property (|drive_o.primary_on);
  cover property (secondary_overvoltage_sense_pin_i [*7]);
endmodule
bind balance_command_fault_gate balance_command_fault_gate_properties chk_i (.*);

/* File: dv/balance_command_fault_gate_test.sv */
`timescale 1ns/1ps
module balance_command_fault_gate_test;
  import balance_gate_pkg::*;
  localparam logic [4:0] ADDR = 5'h0B;
  logic core_clk_i = 1'h0, reset_n_i = 1'h0, execute_i = 1'h0, ov = 1'h0, susp = 1'h0;
  logic [5:0] used = 6'h3F;
  logic pk = 1'h0;
  logic wv, ok, err;
  logic [4:0] wa;
  logic [11:0] s;
  balance_word_t ww, rb;
  switch_drive_t drv;
  int mismatches = 0;
  int n_tests = 0;
  always #4 core_clk_i = ~core_clk_i;
  host_model host_model_i (.clk_i(core_clk_i), .rb_i(rb), .valid_o(wv), .addr_o(wa),
    .word_o(ww), .rb_ok_o(ok));
  balance_command_fault_gate balance_command_fault_gate_i (.core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i), .device_addr_i(ADDR), .write_valid_i(wv), .write_addr_i(wa),
    .write_word_i(ww), .execute_i(execute_i), .suspend_i(susp), .cell_used_i(used),
    .secondary_overvoltage_sense_pin_i(ov), .primary_peak_i(pk), .secondary_peak_i(pk),
    .primary_max_on_time_set_i(16'h0005), .secondary_max_on_time_set_i(16'h0007),
    .crc_error_o(err), .readback_word_o(rb), .drive_o(drv));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Everything the drive showed over n cycles; ends on a rising edge
  task automatic run(input int n);
    s = 12'h000;
    repeat (n) begin
      @(negedge core_clk_i);
      s |= drv;
    end
    @(posedge core_clk_i);
  endtask
  task automatic exec_cmd;
    @(posedge core_clk_i);
    execute_i <= 1'h1;
    @(posedge core_clk_i);
    execute_i <= 1'h0;
  endtask
  task automatic t_good;
    host_model_i.send(ADDR, 12'hC10, 1'h0);
    #1 chk(rb, 16'hC102);
    chk({err, ok}, 16'h0001);
    exec_cmd();
    run(20);
    chk(s, 12'h201);
    pk <= 1'h1;
    run(6);
    pk <= 1'h0;
    chk(s, 12'h201);
  endtask
  task automatic t_bad;
    host_model_i.send(ADDR, 12'hC10, 1'h1);
    #1 chk({err, rb}, 17'h1C102);
    exec_cmd();
    run(10);
    chk(s, 12'h000);
  endtask
  task automatic t_unused;
    used <= 6'h3E;
    host_model_i.send(ADDR, 12'hC10, 1'h0);
    host_model_i.send(ADDR ^ 5'h01, 12'h400, 1'h1);
    #1 chk({err, rb}, 17'h0C102);
    exec_cmd();
    run(20);
    chk(s, 12'h200);
  endtask
  task automatic t_stop;
    ov <= 1'h1;
    run(8);
    run(4);
    chk(s, 12'h000);
    ov <= 1'h0;
    run(6);
    chk(s, 12'h000);
    exec_cmd();
    susp <= 1'h1;
    run(3);
    run(4);
    chk(s, 12'h000);
  endtask
  task automatic t_reset;
    susp <= 1'h0;
    reset_n_i <= 1'h0;
    repeat (2) @(posedge core_clk_i);
    reset_n_i <= 1'h1;
    exec_cmd();
    run(10);
    chk({err, rb, s}, 29'h0000000);
  endtask
  task automatic close_out;
    if (mismatches == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #20000;
    mismatches++;
    close_out();
  end
  initial begin
    repeat (10) @(posedge core_clk_i);
    reset_n_i <= 1'h1;
    run(3);
    chk({err, s}, 13'h0000);
    t_good();
    t_bad();
    t_unused();
    t_stop();
    t_reset();
    close_out();
  end
endmodule
